/* File: src/fcd_pkg.sv */
// Package: register map, command codes and carrier types of the flash command controller
package fcd_pkg;
	localparam int FCD_ADDR_W = 25;
	localparam int FCD_DIE_BIT = 24;
	localparam int FCD_DQ_W = 16;
	// Register byte offsets on the AHB-Lite port
	localparam logic [7:0] FCD_OFS_ADDR = 8'h00;
	localparam logic [7:0] FCD_OFS_DATA = 8'h04;
	localparam logic [7:0] FCD_OFS_CMD = 8'h08;
	localparam logic [7:0] FCD_OFS_STAT = 8'h0C;
	localparam logic [7:0] FCD_OFS_RDATA = 8'h10;
	localparam logic [7:0] FCD_OFS_CFG = 8'h14;
	// Fields of the controller status word
	localparam int FCD_ST_BUSY = 8;
	localparam int FCD_ST_REFUSED = 9;
	localparam int FCD_ST_UPPER_ERR = 10;
	localparam int FCD_ST_PIN_BUSY = 11;
	localparam int FCD_ST_MODE_LSB = 12;
	// Device status byte layout
	localparam logic [7:0] FCD_STATUS_RESET = 8'h80;
	localparam logic [7:0] FCD_STATUS_ERR_MASK = 8'h3A;
	localparam logic [6:0] FCD_STATUS_LOW_ZERO = 7'h00;
	localparam logic [7:0] FCD_UPPER_ZERO = 8'h00;
	localparam int FCD_READY_BIT = 7;
	// Command codes on the data bus
	localparam logic [15:0] FCD_C_RD_ARRAY = 16'h00FF;
	localparam logic [15:0] FCD_C_RD_STATUS = 16'h0070;
	localparam logic [15:0] FCD_C_RD_ID = 16'h0090;
	localparam logic [15:0] FCD_C_CFI = 16'h0098;
	localparam logic [15:0] FCD_C_CLR_STATUS = 16'h0050;
	localparam logic [15:0] FCD_C_SUSPEND = 16'h00B0;
	localparam logic [15:0] FCD_C_CONFIRM = 16'h00D0;
	localparam logic [15:0] FCD_C_PROGRAM = 16'h0040;
	localparam logic [15:0] FCD_C_BUF_PROG = 16'h00E8;
	localparam logic [15:0] FCD_C_ERASE = 16'h0020;
	localparam logic [15:0] FCD_C_LOCK_SETUP = 16'h0060;
	localparam logic [15:0] FCD_C_LOCK = 16'h0001;
	localparam logic [15:0] FCD_C_ECR = 16'h0004;
	localparam logic [15:0] FCD_C_STS_CFG = 16'h00B8;
	localparam logic [15:0] FCD_C_OTP = 16'h00C0;
	localparam logic [15:0] FCD_C_NONE = 16'h0000;
	typedef enum logic [3:0] {
		FCD_OP_READ = 4'h0, FCD_OP_RD_ARRAY = 4'h1, FCD_OP_RD_STATUS = 4'h2, FCD_OP_RD_ID = 4'h3,
		FCD_OP_CFI = 4'h4, FCD_OP_CLR_STATUS = 4'h5, FCD_OP_SUSPEND = 4'h6, FCD_OP_RESUME = 4'h7,
		FCD_OP_PROGRAM = 4'h8, FCD_OP_BUF_PROG = 4'h9, FCD_OP_ERASE = 4'hA, FCD_OP_LOCK = 4'hB,
		FCD_OP_UNLOCK = 4'hC, FCD_OP_ECR = 4'hD, FCD_OP_STS_CFG = 4'hE, FCD_OP_OTP = 4'hF
	} fcd_op_type;
	typedef enum logic [1:0] {
		FCD_MODE_ARRAY = 2'h0, FCD_MODE_STATUS = 2'h1, FCD_MODE_ID = 2'h2, FCD_MODE_CFI = 2'h3
	} fcd_mode_type;
	typedef struct packed {
		logic [15:0] first;
		logic [15:0] second;
		logic two_cycle;
		logic second_user;
		logic guarded;
		logic die_base;
		logic addr_from_data;
		logic sets_mode;
		fcd_mode_type mode;
	} fcd_info_type;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [FCD_ADDR_W-1:0] addr;
		logic [FCD_DQ_W-1:0] dq_out;
		logic dq_oe;
	} fcd_pins_type;
endpackage

/* File: src/fcd_bus_cycle.sv */
// One asynchronous flash bus cycle, read or write, paced by a tick divider
`timescale 1ns/1ps
module fcd_bus_cycle import fcd_pkg::*; #(
	parameter int TICK_DIV = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic is_write,
	input wire logic [FCD_ADDR_W-1:0] addr,
	input wire logic [FCD_DQ_W-1:0] wdata,
	input wire logic [FCD_DQ_W-1:0] dq_in,
	output fcd_pins_type pins,
	output logic done,
	output logic [FCD_DQ_W-1:0] rdata
);
	// Read sampling sees the pins two cycles late, so a phase must outlast the synchroniser
	initial begin
		if (TICK_DIV < 3) $error("TICK_DIV must be at least 3");
	end
	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001, PH_SETUP = 4'b0010, PH_STROBE = 4'b0100, PH_HOLD = 4'b1000
	} fcd_phase_type;
	fcd_phase_type phase_reg;
	logic [$clog2(TICK_DIV)-1:0] div_reg;
	logic tick;
	logic [FCD_DQ_W-1:0] dq_meta_reg, dq_sync_reg;
	logic write_reg;

	assign tick = (div_reg == $bits(div_reg)'(TICK_DIV - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) div_reg <= '0;
		else if (phase_reg == PH_IDLE || tick) div_reg <= '0;
		else div_reg <= div_reg + 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_meta_reg <= '0;
			dq_sync_reg <= '0;
		end else begin
			dq_meta_reg <= dq_in;
			dq_sync_reg <= dq_meta_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= PH_IDLE;
			pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
			done <= 1'b0;
			rdata <= '0;
			write_reg <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (phase_reg)
				PH_IDLE: begin
					if (start) begin
						phase_reg <= PH_SETUP;
						write_reg <= is_write;
						pins.ce_n <= 1'b0;
						pins.addr <= addr;
						pins.dq_out <= wdata;
						pins.dq_oe <= is_write;
					end
				end
				PH_SETUP: begin
					if (tick) begin
						phase_reg <= PH_STROBE;
						pins.we_n <= !write_reg;
						pins.oe_n <= write_reg;
					end
				end
				PH_STROBE: begin
					if (tick) begin
						// Writes latch on the rising strobe; one word per read access
						phase_reg <= PH_HOLD;
						pins.we_n <= 1'b1;
						pins.oe_n <= 1'b1;
						if (!write_reg) rdata <= dq_sync_reg;
					end
				end
				PH_HOLD: begin
					if (tick) begin
						// Deselect after every access so the next status read relatches
						phase_reg <= PH_IDLE;
						pins.ce_n <= 1'b1;
						pins.dq_oe <= 1'b0;
						done <= 1'b1;
					end
				end
			endcase
		end
	end

	strobes_released_a: assert property (@(posedge hclk) disable iff (!hresetn)
		done |-> pins.oe_n && pins.we_n && pins.ce_n)
		else $error("strobes still active at cycle end");
	single_access_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(pins.oe_n) |-> !pins.ce_n ##1 !pins.oe_n [*2])
		else $error("read strobe shorter than one phase");
endmodule // fcd_bus_cycle

/* File: src/fcd_controller.sv */
// Host-side flash command controller: AHB-Lite registers in, flash command cycles out
//
// Contract
// - Setup then confirm, no write between
// - Program 0040h+data; erase 0020h, 00D0h block
// - Buffered program 00E8h then confirm 00D0h
// - Lock 0060h/0001h; unlock 0060h/00D0h
// - ECR 0060h/0004h on address; B8h; C0h
// - Global commands go to the die base; suspend and resume are sent to the address register instead
// - Confirm write keeps the setup address; the OTP confirm here goes to the address register instead
// - Status read is one single access
// - Strobes return high between status reads
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module fcd_controller import fcd_pkg::*; #(
	parameter int TICK_DIV = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [FCD_DQ_W-1:0] flash_dq_in,
	input wire logic busy_indicator_pin,
	output fcd_pins_type flash_pins,
	output logic program_enable_high_level
);
	// Per-operation command table; the data register becomes the word for data-carrying confirms
	function automatic fcd_info_type op_info(input fcd_op_type op);
		fcd_info_type i;
		i = '{first: FCD_C_NONE, second: FCD_C_NONE, two_cycle: 1'b0, second_user: 1'b0, guarded: 1'b0,
			die_base: 1'b1, addr_from_data: 1'b0, sets_mode: 1'b0, mode: FCD_MODE_ARRAY};
		unique case (op)
			FCD_OP_READ: i.die_base = 1'b0;
			FCD_OP_RD_ARRAY: i = '{FCD_C_RD_ARRAY, FCD_C_NONE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, FCD_MODE_ARRAY};
			FCD_OP_RD_STATUS: i = '{FCD_C_RD_STATUS, FCD_C_NONE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_RD_ID: i = '{FCD_C_RD_ID, FCD_C_NONE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, FCD_MODE_ID};
			FCD_OP_CFI: i = '{FCD_C_CFI, FCD_C_NONE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, FCD_MODE_CFI};
			FCD_OP_CLR_STATUS: i = '{FCD_C_CLR_STATUS, FCD_C_NONE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_SUSPEND: i = '{FCD_C_SUSPEND, FCD_C_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, FCD_MODE_ARRAY};
			FCD_OP_RESUME: i = '{FCD_C_CONFIRM, FCD_C_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_PROGRAM: i = '{FCD_C_PROGRAM, FCD_C_NONE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_BUF_PROG: i = '{FCD_C_BUF_PROG, FCD_C_CONFIRM, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_ERASE: i = '{FCD_C_ERASE, FCD_C_CONFIRM, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_LOCK: i = '{FCD_C_LOCK_SETUP, FCD_C_LOCK, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_UNLOCK: i = '{FCD_C_LOCK_SETUP, FCD_C_CONFIRM, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, FCD_MODE_STATUS};
			FCD_OP_ECR: i = '{FCD_C_LOCK_SETUP, FCD_C_ECR, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, FCD_MODE_ARRAY};
			FCD_OP_STS_CFG: i = '{FCD_C_STS_CFG, FCD_C_NONE, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, FCD_MODE_ARRAY};
			FCD_OP_OTP: i = '{FCD_C_OTP, FCD_C_NONE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, FCD_MODE_STATUS};
		endcase
		return i;
	endfunction

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001, ST_FIRST = 4'b0010, ST_SECOND = 4'b0100, ST_READ = 4'b1000
	} fcd_state_type;
	fcd_state_type state_reg;
	fcd_op_type op_reg;
	fcd_info_type info;
	fcd_mode_type mode_reg;
	logic [31:0] addr_reg, data_reg;
	logic [FCD_DQ_W-1:0] rdata_reg;
	logic [7:0] status_reg;
	logic refused_reg, upper_err_reg, program_enable_supply_reg;
	logic pin_meta_reg, pin_sync_reg;
	logic [7:0] ofs_reg;
	logic wr_pend_reg, start_reg, write_cyc_reg;
	logic [FCD_ADDR_W-1:0] cyc_addr_reg, first_addr_reg;
	logic [FCD_DQ_W-1:0] cyc_data_reg;
	logic cyc_done;
	logic [FCD_DQ_W-1:0] cyc_rdata;
	logic addr_phase, cmd_write;
	fcd_op_type new_op;
	fcd_info_type new_info;
	logic [FCD_ADDR_W-1:0] base_addr;

	assign info = op_info(op_reg);
	assign addr_phase = hsel && hready && htrans[1];
	assign cmd_write = wr_pend_reg && (ofs_reg == FCD_OFS_CMD);
	assign new_op = fcd_op_type'(hwdata[3:0]);
	assign new_info = op_info(new_op);
	assign base_addr = addr_reg[FCD_ADDR_W-1:0] & (FCD_ADDR_W'(1) << FCD_DIE_BIT);

	// Busy pin is asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
		end else begin
			pin_meta_reg <= busy_indicator_pin;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			ofs_reg <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase) ofs_reg <= haddr[7:0];
			if (addr_phase && !hwrite) begin
				unique case (haddr[7:0])
					FCD_OFS_ADDR: hrdata <= addr_reg;
					FCD_OFS_DATA: hrdata <= data_reg;
					FCD_OFS_CMD: hrdata <= {28'h0000000, op_reg};
					FCD_OFS_STAT: hrdata <= {16'h0000, 2'b00, mode_reg, pin_sync_reg, upper_err_reg, refused_reg,
						state_reg != ST_IDLE, status_reg};
					FCD_OFS_RDATA: hrdata <= {16'h0000, rdata_reg};
					FCD_OFS_CFG: hrdata <= {31'h00000000, program_enable_supply_reg};
					default: hrdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= '0;
			data_reg <= '0;
			program_enable_supply_reg <= 1'b0;
			program_enable_high_level <= 1'b0;
		end else begin
			if (wr_pend_reg && ofs_reg == FCD_OFS_ADDR) addr_reg <= hwdata;
			if (wr_pend_reg && ofs_reg == FCD_OFS_DATA) data_reg <= hwdata;
			if (wr_pend_reg && ofs_reg == FCD_OFS_CFG) program_enable_supply_reg <= hwdata[0];
			program_enable_high_level <= program_enable_supply_reg;
		end
	end

	// Command sequencer; the second write follows the first with nothing between
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			op_reg <= FCD_OP_READ;
			start_reg <= 1'b0;
			write_cyc_reg <= 1'b0;
			cyc_addr_reg <= '0;
			first_addr_reg <= '0;
			cyc_data_reg <= '0;
			refused_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (cmd_write) begin
						// Refused while busy, or a guarded op with the supply low
						if (new_info.guarded && !program_enable_supply_reg) refused_reg <= 1'b1;
						else begin
							refused_reg <= 1'b0;
							op_reg <= new_op;
							start_reg <= 1'b1;
							cyc_data_reg <= new_info.first;
							write_cyc_reg <= (new_op != FCD_OP_READ);
							if (new_info.addr_from_data) cyc_addr_reg <= FCD_ADDR_W'(data_reg[15:0]);
							else if (new_info.die_base) cyc_addr_reg <= base_addr;
							else cyc_addr_reg <= addr_reg[FCD_ADDR_W-1:0];
							state_reg <= (new_op == FCD_OP_READ) ? ST_READ : ST_FIRST;
						end
					end
				end
				ST_FIRST: begin
					first_addr_reg <= cyc_addr_reg;
					if (cyc_done) begin
						if (info.two_cycle) begin
							start_reg <= 1'b1;
							state_reg <= ST_SECOND;
							cyc_data_reg <= info.second_user ? data_reg[FCD_DQ_W-1:0] : info.second;
							// OTP confirm carries the register offset; the rest keep the setup address
							if (op_reg == FCD_OP_OTP) cyc_addr_reg <= addr_reg[FCD_ADDR_W-1:0];
							else cyc_addr_reg <= first_addr_reg;
						end else state_reg <= ST_IDLE;
					end
				end
				ST_SECOND, ST_READ: begin
					if (cyc_done) state_reg <= ST_IDLE;
				end
			endcase
			if (cmd_write && state_reg != ST_IDLE) refused_reg <= 1'b1;
		end
	end

	// Read-mode tracking mirrors the device so status reads are recognised
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) mode_reg <= FCD_MODE_ARRAY;
		else if (cyc_done && info.sets_mode && (state_reg == ST_SECOND || (state_reg == ST_FIRST && !info.two_cycle)))
			mode_reg <= info.mode;
	end

	// Status copy: bits below 7 are only trusted when ready; bit 0 is reserved
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= FCD_STATUS_RESET;
			upper_err_reg <= 1'b0;
			rdata_reg <= '0;
		end else if (cyc_done && state_reg == ST_READ) begin
			rdata_reg <= cyc_rdata;
			if (mode_reg == FCD_MODE_STATUS) begin
				upper_err_reg <= (cyc_rdata[15:8] != FCD_UPPER_ZERO);
				if (cyc_rdata[FCD_READY_BIT]) status_reg <= {cyc_rdata[7:1], 1'b0};
				else status_reg <= {1'b0, FCD_STATUS_LOW_ZERO};
			end
		end else if (cyc_done && state_reg == ST_FIRST && op_reg == FCD_OP_CLR_STATUS)
			status_reg <= status_reg & ~FCD_STATUS_ERR_MASK;
	end

	fcd_bus_cycle #(
		.TICK_DIV(TICK_DIV)
	) u_cycle (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(start_reg),
		.is_write(write_cyc_reg),
		.addr(cyc_addr_reg),
		.wdata(cyc_data_reg),
		.dq_in(flash_dq_in),
		.pins(flash_pins),
		.done(cyc_done),
		.rdata(cyc_rdata)
	);

	supply_guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start_reg && state_reg == ST_FIRST |-> !info.guarded || program_enable_supply_reg)
		else $error("guarded command issued with supply low");
	confirm_follows_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cyc_done && state_reg == ST_FIRST && info.two_cycle |=> start_reg && state_reg == ST_SECOND)
		else $error("confirm write not issued at once");
	single_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cyc_done && state_reg == ST_FIRST && !info.two_cycle |=> state_reg == ST_IDLE)
		else $error("one-write command did not finish");
	same_address_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start_reg && state_reg == ST_SECOND && op_reg != FCD_OP_OTP && op_reg != FCD_OP_ECR
		|-> cyc_addr_reg == $past(cyc_addr_reg, 1))
		else $error("confirm address differs from setup");
	status_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cyc_done && state_reg == ST_FIRST && op_reg == FCD_OP_CLR_STATUS |=> mode_reg == FCD_MODE_STATUS)
		else $error("clear status left another read mode");
	erase_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cyc_done && state_reg == ST_SECOND && op_reg == FCD_OP_ERASE |=> mode_reg == FCD_MODE_STATUS)
		else $error("erase did not select status mode");
	busy_masks_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!status_reg[FCD_READY_BIT] |-> status_reg[6:0] == FCD_STATUS_LOW_ZERO)
		else $error("busy status kept invalid bits");
	reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		status_reg[0] == 1'b0)
		else $error("reserved status bit set");
endmodule // fcd_controller

/* File: verification/fcd_flash_model.sv */
// Behavioural flash device facing the controller's pins
`timescale 1ns/1ps
module fcd_flash_model import fcd_pkg::*; #(
	parameter int BUSY_CYC = 150,
	parameter logic [15:0] ID_CODE = 16'h5A3C, // Arbitrary value
	parameter logic [15:0] CFI_WORD = 16'h0123 // Arbitrary value
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire fcd_pins_type pins,
	input wire logic supply_high,
	input wire logic supply_fault,
	output logic [15:0] dq,
	output logic busy
);
	logic [7:0] status_reg, latch_reg;
	fcd_mode_type mode_reg;
	logic pend_reg, susp_reg, erasing_reg, we_q, oe_q, ce_q;
	logic [15:0] setup_reg;
	logic [24:0] setup_addr_reg;
	logic [255:0] lock_reg;
	logic [15:0] log_d [2];
	logic [24:0] log_a [2];
	int busy_cnt;
	logic [15:0] mem [logic [24:0]];
	assign busy = ~status_reg[7];
	logic [7:0] shown;
	// A busy device leaves the low bits undriven; the inverse stands in for that
	assign shown = status_reg[7] ? status_reg : {1'b0, ~status_reg[6:0]};
	function automatic logic [15:0] arr(input logic [24:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	task automatic start_op(input logic is_erase, input logic [24:0] a, input logic [15:0] d);
		mode_reg <= FCD_MODE_STATUS;
		if (!supply_high || supply_fault) status_reg[3] <= 1'b1;
		else if (lock_reg[a[24:17]]) status_reg <= status_reg | (is_erase ? 8'h22 : 8'h12);
		else begin
			if (!is_erase) mem[a] = arr(a) & d;
			busy_cnt <= BUSY_CYC;
			erasing_reg <= is_erase;
			status_reg[7] <= 1'b0;
		end
	endtask
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= FCD_STATUS_RESET;
			latch_reg <= FCD_STATUS_RESET;
			mode_reg <= FCD_MODE_ARRAY;
			{pend_reg, susp_reg, erasing_reg} <= 3'h0;
			{we_q, oe_q, ce_q} <= 3'h7;
			lock_reg <= '0;
			busy_cnt <= 0;
			dq <= 16'h0000;
			setup_reg <= 16'h0000;
			setup_addr_reg <= '0;
			log_d <= '{16'h0000, 16'h0000};
			log_a <= '{25'h0, 25'h0};
		end else begin
			we_q <= pins.we_n;
			oe_q <= pins.oe_n;
			ce_q <= pins.ce_n;
			if (busy_cnt > 0 && !susp_reg) begin
				busy_cnt <= busy_cnt - 1;
				if (busy_cnt == 1) status_reg[7] <= 1'b1;
			end
			// Frozen until a strobe falls again, so a held strobe shows stale status
			if (!pins.ce_n && !pins.oe_n && (oe_q || ce_q))
				latch_reg <= shown;
			if (!pins.ce_n && !pins.oe_n) begin
				case (mode_reg)
				FCD_MODE_ARRAY: dq <= arr(pins.addr);
				FCD_MODE_STATUS: dq <= {FCD_UPPER_ZERO, (oe_q || ce_q) ? shown : latch_reg};
				FCD_MODE_ID: dq <= ID_CODE;
				default: dq <= CFI_WORD;
				endcase
			end else dq <= ~dq;
			if (!we_q && pins.we_n && !pins.ce_n) begin
				// Newest write in slot 0; an undriven bus logs the inverse
				log_d <= '{(pins.dq_oe ? pins.dq_out : ~pins.dq_out), log_d[0]};
				log_a <= '{pins.addr, log_a[0]};
				pend_reg <= 1'b0;
				if (pend_reg) begin
					case (setup_reg)
					FCD_C_PROGRAM: start_op(1'b0, pins.addr, pins.dq_out);
					FCD_C_ERASE, FCD_C_BUF_PROG: begin
						if (pins.dq_out == FCD_C_CONFIRM) start_op(setup_reg == FCD_C_ERASE, setup_addr_reg, 16'hFFFF);
						else status_reg <= status_reg | 8'h30;
					end
					FCD_C_LOCK_SETUP: begin
						if (pins.dq_out == FCD_C_LOCK) lock_reg[setup_addr_reg[24:17]] <= 1'b1;
						else if (pins.dq_out == FCD_C_CONFIRM) lock_reg <= '0;
						mode_reg <= (pins.dq_out == FCD_C_ECR) ? FCD_MODE_ARRAY : FCD_MODE_STATUS;
					end
					FCD_C_OTP: mode_reg <= FCD_MODE_STATUS;
					default: ;
					endcase
				end else begin
					case (pins.dq_out)
					FCD_C_RD_ARRAY: mode_reg <= FCD_MODE_ARRAY;
					FCD_C_RD_STATUS: mode_reg <= FCD_MODE_STATUS;
					FCD_C_RD_ID: mode_reg <= FCD_MODE_ID;
					FCD_C_CFI: mode_reg <= FCD_MODE_CFI;
					FCD_C_CLR_STATUS: begin
						status_reg <= status_reg & ~FCD_STATUS_ERR_MASK;
						mode_reg <= FCD_MODE_STATUS;
					end
					FCD_C_SUSPEND: if (busy_cnt > 0 && !susp_reg) begin
						susp_reg <= 1'b1;
						status_reg[7] <= 1'b1;
						status_reg[erasing_reg ? 6 : 2] <= 1'b1;
					end
					FCD_C_CONFIRM: if (susp_reg) begin
						susp_reg <= 1'b0;
						status_reg[7] <= 1'b0;
						status_reg[6] <= 1'b0;
						status_reg[2] <= 1'b0;
					end
					default: begin
						pend_reg <= 1'b1;
						setup_reg <= pins.dq_out;
						setup_addr_reg <= pins.addr;
					end
					endcase
				end
			end
		end
	end
endmodule // fcd_flash_model

/* File: verification/tb_top.sv */
// Testbench: controller registers driven over AHB-Lite against the flash model
`timescale 1ns/1ps
module tb_top;
	import fcd_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
	localparam logic [15:0] ID_VAL = 16'h5A3C; // Arbitrary value
	localparam logic [15:0] CFI_VAL = 16'h0123; // Arbitrary value
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pe_high, fault, busy;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] dq, d0;
	logic [24:0] a0;
	fcd_pins_type pins;
	int error_cnt, n_compared, cyc;
	logic [3:0] t_op [7] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
	logic [15:0] t_first [7] = '{16'h00E8, 16'h0020, 16'h0060, 16'h0060, 16'h0060, 16'h00B8, 16'h00C0};
	logic [15:0] t_second [7] = '{16'h00D0, 16'h00D0, 16'h0001, 16'h00D0, 16'h0004, 16'h2000, 16'h2000};
	fcd_controller fcd_controller_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .flash_dq_in(dq), .busy_indicator_pin(busy), .flash_pins(pins), .program_enable_high_level(pe_high));
	fcd_flash_model #(.ID_CODE(ID_VAL), .CFI_WORD(CFI_VAL)) fcd_flash_model_inst (.hclk(hclk), .hresetn(hresetn),
		.pins(pins), .supply_high(pe_high), .supply_fault(fault), .dq(dq), .busy(busy));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Generous ceiling: the full sequence needs well under a third of it
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic cmd(input logic [3:0] op, input logic [24:0] a, input logic [15:0] d);
		xfer(1'b1, FCD_OFS_ADDR, {7'h00, a});
		xfer(1'b1, FCD_OFS_DATA, {16'h0000, d});
		xfer(1'b1, FCD_OFS_CMD, {28'h0000000, op});
		do xfer(1'b0, FCD_OFS_STAT, 32'h0); while (r[FCD_ST_BUSY] !== 1'b0);
	endtask
	task automatic rstat();
		cmd(FCD_OP_READ, a0, 16'h0000);
		xfer(1'b0, FCD_OFS_STAT, 32'h0);
	endtask
	task automatic rdy();
		do rstat(); while (r[FCD_READY_BIT] !== 1'b1);
	endtask
	initial begin
		{hsel, hwrite, hresetn, fault} = 4'h0;
		{htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		a0 = 25'h0000010;
		void'($urandom(32'hc4faabec));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, FCD_OFS_STAT, 32'h0);
		`CHK("reset status", 8'h80, r[7:0])
		`CHK("reset mode", 2'h0, r[13:12])
		`CHK("okay response", 1'b0, hresp)
		xfer(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, r)
		cmd(FCD_OP_PROGRAM, 25'h100, 16'h1234);
		xfer(1'b0, FCD_OFS_STAT, 32'h0);
		`CHK("refused low supply", 1'b1, r[FCD_ST_REFUSED])
		cmd(FCD_OP_RD_STATUS, a0, 16'h0000);
		rstat();
		`CHK("status low supply", 8'h80, r[7:0])
		`CHK("upper byte", 1'b0, r[FCD_ST_UPPER_ERR])
		`CHK("status mode", 2'h1, r[13:12])
		xfer(1'b1, FCD_OFS_CFG, 32'h1);
		for (int i = 0; i < 4; i++) begin
			a0 = 25'($urandom) & 25'h0FFFFFF;
			d0 = 16'($urandom);
			cmd(FCD_OP_PROGRAM, a0, d0);
			rdy();
			`CHK("program ok", 8'h80, r[7:0])
			`CHK("program mode", 2'h1, r[13:12])
			cmd(FCD_OP_RD_ARRAY, a0, 16'h0000);
			cmd(FCD_OP_READ, a0, 16'h0000);
			xfer(1'b0, FCD_OFS_RDATA, 32'h0);
			`CHK("program data", d0, r[15:0])
		end
		for (int i = 0; i < 3; i++) begin
			cmd(i == 0 ? FCD_OP_RD_ID : i == 1 ? FCD_OP_CFI : FCD_OP_RD_ARRAY, a0, 16'h0000);
			cmd(FCD_OP_READ, a0, 16'h0000);
			xfer(1'b0, FCD_OFS_RDATA, 32'h0);
			`CHK("mode data", i == 0 ? ID_VAL : i == 1 ? CFI_VAL : d0, r[15:0])
		end
		cmd(FCD_OP_LOCK, 25'h0120000, 16'h0000);
		cmd(FCD_OP_PROGRAM, 25'h0120010, 16'h00FF);
		rdy();
		`CHK("locked program", 8'h92, r[7:0])
		cmd(FCD_OP_ERASE, 25'h0120000, 16'h0000);
		rdy();
		`CHK("errors sticky", 8'hB2, r[7:0])
		cmd(FCD_OP_CLR_STATUS, a0, 16'h0000);
		rstat();
		`CHK("cleared", 8'h80, r[7:0])
		`CHK("clear mode", 2'h1, r[13:12])
		cmd(FCD_OP_UNLOCK, a0, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			cmd(i == 0 ? FCD_OP_ERASE : FCD_OP_PROGRAM, 25'h0140000, 16'h0F0F);
			rstat();
			`CHK("busy status", 8'h00, r[7:0])
			`CHK("busy pin", 1'b1, r[FCD_ST_PIN_BUSY])
			cmd(FCD_OP_SUSPEND, a0, 16'h0000);
			rstat();
			`CHK("suspended", i == 0 ? 8'hC0 : 8'h84, r[7:0])
			cmd(FCD_OP_RESUME, a0, 16'h0000);
			rdy();
			`CHK("resumed", 8'h80, r[7:0])
		end
		for (int i = 0; i < 7; i++) begin
			cmd(t_op[i], 25'h1040010, 16'h2000);
			`CHK("first code", t_first[i], fcd_flash_model_inst.log_d[1])
			`CHK("second code", t_second[i], fcd_flash_model_inst.log_d[0])
			if (t_op[i] <= 4'hD) `CHK("same address", fcd_flash_model_inst.log_a[1], fcd_flash_model_inst.log_a[0])
			if (t_op[i] >= 4'hC && t_op[i] != 4'hD) `CHK("die base", 25'h1000000, fcd_flash_model_inst.log_a[1])
			if (t_op[i] == 4'hD) `CHK("config on address", 25'h0002000, fcd_flash_model_inst.log_a[0])
			if (t_op[i] <= 4'hA) rdy();
			if (t_op[i] == 4'hD) begin
				xfer(1'b0, FCD_OFS_STAT, 32'h0);
				`CHK("config mode", 2'h0, r[13:12])
			end
		end
		xfer(1'b0, FCD_OFS_STAT, 32'h0);
		`CHK("otp mode", 2'h1, r[13:12])
		fault <= 1'b1;
		cmd(FCD_OP_PROGRAM, a0, 16'h0000);
		rdy();
		`CHK("supply fault", 8'h88, r[7:0])
		fault <= 1'b0;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, FCD_OFS_STAT, 32'h0);
		`CHK("status after reset", 8'h80, r[7:0])
		`CHK("mode after reset", 2'h0, r[13:12])
		complete_run();
	end
endmodule // tb_top
